// File: logic/ddsc_consts.svh
// Constants for the disk drive status and clock output block.
`ifndef DDSC_CONSTS_SVH
`define DDSC_CONSTS_SVH
`define DDSC_CLK_KHZ         40000
`define DDSC_SERVO_PER_BYTE  8
`define DDSC_BYTE_HALF       4
`define DDSC_BYTES_PER_REV   13440
`define DDSC_POS_W           14
`define DDSC_INDEX_NS        1240
`define DDSC_INDEX_CYC       ((`DDSC_INDEX_NS * `DDSC_CLK_KHZ + 999999) / 1000000)
`define DDSC_CLEAR_MAX_NS    500
`define DDSC_CLEAR_MAX_CYC   ((`DDSC_CLEAR_MAX_NS * `DDSC_CLK_KHZ) / 1000000)
`define DDSC_SEL_MAX_NS      1000
`define DDSC_SEL_MAX_CYC     ((`DDSC_SEL_MAX_NS * `DDSC_CLK_KHZ) / 1000000)
`define DDSC_LOCK_PERIODS    88
`define DDSC_ADR_CTRL        8'h00
`define DDSC_ADR_STATUS      8'h04
`define DDSC_ADR_BYTE_POS    8'h08
`define DDSC_CTRL_RST        1'h1
`define DDSC_CTRL_BYTE_EN    0
`define DDSC_CTRL_CLR        1
`define DDSC_ST_FAULT        0
`define DDSC_ST_LOCKED       1
`define DDSC_ST_SELECTED     2
`define DDSC_ST_CAPACITY     3
`define DDSC_ST_READ_GATE    4
`define DDSC_ST_RUNNING      5
`endif

// File: logic/ddsc_pkg.sv
// Types shared by the disk drive status and clock output block.
package ddsc_pkg;
  typedef enum logic [1:0] {DDSC_RD_IDLE, DDSC_RD_ACQ, DDSC_RD_LOCK} ddsc_rd_e;
  typedef struct packed {
    logic [2:0]  servo_cnt;
    logic [13:0] byte_pos;
    logic [5:0]  idx_cnt;
    logic        byte_clk;
    logic        byte_pulse;
    logic        index;
  } ddsc_tmr_s;
  typedef struct packed {
    logic        byte_en;
    logic        clr_pulse;
    logic        fault;
    logic        wdrive;
    ddsc_rd_e    rd;
    logic [6:0]  zero_cnt;
    logic        lock_start;
    logic        rd_data;
    logic        clk_out;
    logic        selected;
    logic        capacity;
    logic        ack;
    logic [31:0] dat;
  } ddsc_main_s;
endpackage : ddsc_pkg

// File: logic/ddsc_sync.sv
// Two-flop synchroniser with a rising edge flag per bit.
`timescale 1ns/10ps
module ddsc_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Asynchronous levels in, clean levels and edges out.
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o,
  output logic      [W-1:0] rise_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } ddsc_sync_s;
  ddsc_sync_s s_reg;
  ddsc_sync_s s_next;
  // The edge is taken from the second and third stages so the first stays private.
  always_comb begin
    s_next    = s_reg;
    s_next.s1 = d_i;
    s_next.s2 = s_reg.s1;
    s_next.s3 = s_reg.s2;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
  assign q_o    = s_reg.s2;
  assign rise_o = s_reg.s2 & ~s_reg.s3;
endmodule : ddsc_sync

// File: logic/ddsc_byte_timer.sv
// Byte clock, byte position and track start marker from the servo clock.
`timescale 1ns/10ps
`include "ddsc_consts.svh"
module ddsc_byte_timer (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Servo clock edges and run qualifier.
  input  wire logic        servo_rise_i,
  input  wire logic        run_i,
  // Timing outputs.
  output logic             byte_clk_o,
  output logic             byte_pulse_o,
  output logic             index_o,
  output logic [13:0]      byte_pos_o
);
  localparam int IDX_CYC = `DDSC_INDEX_CYC;
  ddsc_pkg::ddsc_tmr_s s_reg;
  ddsc_pkg::ddsc_tmr_s s_next;
  logic [3:0] rise_seen;
  logic [6:0] idx_high;
  always_comb begin
    s_next            = s_reg;
    s_next.byte_pulse = 1'b0;
    if (s_reg.index) begin
      if (s_reg.idx_cnt == 6'(IDX_CYC - 1)) begin
        s_next.index = 1'b0;
      end else begin
        s_next.idx_cnt = s_reg.idx_cnt + 6'h01;
      end
    end
    if (!run_i) begin
      // Outside the recording zone or below speed no timing leaves the drive.
      s_next = '0;
    end else if (servo_rise_i) begin
      if (s_reg.servo_cnt == 3'(`DDSC_SERVO_PER_BYTE - 1)) begin
        s_next.servo_cnt  = 3'h0;
        s_next.byte_pulse = 1'b1;
        if (s_reg.byte_pos == 14'(`DDSC_BYTES_PER_REV - 1)) begin
          s_next.byte_pos = 14'h0000;
          s_next.index    = 1'b1;
          s_next.idx_cnt  = 6'h00;
        end else begin
          s_next.byte_pos = s_reg.byte_pos + 14'h0001;
        end
      end else begin
        s_next.servo_cnt = s_reg.servo_cnt + 3'h1;
      end
      s_next.byte_clk = (s_next.servo_cnt < 3'(`DDSC_BYTE_HALF));
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg     <= '0;
      rise_seen <= 4'h0;
      idx_high  <= 7'h00;
    end else begin
      s_reg <= s_next;
      if (!run_i) begin
        rise_seen <= 4'h0;
      end else if (s_reg.byte_pulse) begin
        rise_seen <= {3'h0, servo_rise_i};
      end else if (servo_rise_i) begin
        rise_seen <= rise_seen + 4'h1;
      end
      idx_high <= s_reg.index ? idx_high + 7'h01 : 7'h00;
    end
  end
  assign byte_clk_o   = s_reg.byte_clk;
  assign byte_pulse_o = s_reg.byte_pulse;
  assign index_o      = s_reg.index;
  assign byte_pos_o   = s_reg.byte_pos;
  byte_period_a: assert property (@(posedge clk_i) disable iff (rst_i)
    byte_pulse_o |-> rise_seen == 4'h8)
    else $error("byte pulse not after eight servo edges");
  index_width_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ($fell(index_o) && run_i) |-> idx_high == 7'(IDX_CYC))
    else $error("track start marker has wrong width");
endmodule : ddsc_byte_timer

// File: logic/ddsc_status_clk.sv
// Drive status, byte timing and read clock outputs toward the controller.
`timescale 1ns/10ps
`include "ddsc_consts.svh"
module ddsc_status_clk (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone register port.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Clocks from the spindle servo and the data separator, and the separator's raw read data.
  input  wire logic        servo_clk_i,
  input  wire logic        read_clk_i,
  input  wire logic        read_raw_i,
  // Mechanism and media state.
  input  wire logic        at_speed_i,
  input  wire logic        in_zone_i,
  input  wire logic        drive_ready_i,
  input  wire logic        basic_media_i,
  input  wire logic        optional_media_i,
  // Controller lines.
  input  wire logic        select_i,
  input  wire logic        read_gate_i,
  input  wire logic        write_gate_i,
  input  wire logic [1:0]  head_sel_i,
  input  wire logic        fault_clear_i,
  // Write channel monitors.
  input  wire logic        write_current_i,
  input  wire logic        write_data_act_i,
  input  wire logic        multi_head_i,
  // Status and timing outputs.
  output logic             byte_clk_cmd_o,
  output logic             byte_clk_data_o,
  output logic             index_cmd_o,
  output logic             index_data_o,
  output logic             write_fault_o,
  output logic             capacity_o,
  output logic             unit_selected_o,
  // Clock and data toward the controller.
  output logic             servo_read_clk_o,
  output logic             read_data_o,
  // Internal read and write chain enables.
  output logic             write_drive_en_o,
  output logic             lock_start_o
);
  localparam int NPIN     = 18;
  localparam int P_SERVO  = 0;
  localparam int P_RCLK   = 1;
  localparam int P_RRAW   = 2;
  localparam int P_SPEED  = 3;
  localparam int P_ZONE   = 4;
  localparam int P_READY  = 5;
  localparam int P_BASIC  = 6;
  localparam int P_OPT    = 7;
  localparam int P_SEL    = 8;
  localparam int P_RGATE  = 9;
  localparam int P_WGATE  = 10;
  localparam int P_HEAD0  = 11;
  localparam int P_HEAD1  = 12;
  localparam int P_CLR    = 13;
  localparam int P_WCUR   = 14;
  localparam int P_WDAT   = 15;
  localparam int P_MULTI  = 16;
  localparam int P_SPARE  = 17;
  localparam int CLR_MAX  = `DDSC_CLEAR_MAX_CYC;
  localparam int SEL_MAX  = `DDSC_SEL_MAX_CYC;
  localparam int LOCK_MAX = `DDSC_LOCK_PERIODS;

  ddsc_pkg::ddsc_main_s s_reg;
  ddsc_pkg::ddsc_main_s s_next;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_q;
  logic [NPIN-1:0] pin_rise;
  logic            run;
  logic            bclk;
  logic            bpulse;
  logic            index;
  logic [13:0]     byte_pos;
  logic            wf_cond;
  logic            clr_evt;
  logic            rg_ok;

  assign pin_raw = {1'b0, multi_head_i, write_data_act_i, write_current_i,
                    fault_clear_i, head_sel_i[1], head_sel_i[0], write_gate_i,
                    read_gate_i, select_i, optional_media_i, basic_media_i,
                    drive_ready_i, in_zone_i, at_speed_i, read_raw_i,
                    read_clk_i, servo_clk_i};

  // Every pin crosses in one place so all levels share the same latency.
  ddsc_sync #(
    .W      (NPIN)
  ) u_sync (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .d_i    (pin_raw),
    .q_o    (pin_q),
    .rise_o (pin_rise)
  );

  assign run = pin_q[P_SPEED] & pin_q[P_ZONE] & s_reg.byte_en;

  ddsc_byte_timer u_timer (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .servo_rise_i (pin_rise[P_SERVO]),
    .run_i        (run),
    .byte_clk_o   (bclk),
    .byte_pulse_o (bpulse),
    .index_o      (index),
    .byte_pos_o   (byte_pos)
  );

  // Write fault causes, sampled on synchronised levels.
  always_comb begin
    wf_cond = 1'b0;
    if (pin_q[P_WGATE]) begin
      wf_cond = !pin_q[P_WCUR] || !pin_q[P_WDAT] || !pin_q[P_READY] ||
                (pin_q[P_HEAD1] && pin_q[P_HEAD0]) || pin_q[P_MULTI] ||
                pin_q[P_RGATE];
    end else if (pin_q[P_WCUR]) begin
      wf_cond = 1'b1;
    end
  end

  assign clr_evt = pin_rise[P_CLR] | s_reg.clr_pulse;
  assign rg_ok   = pin_q[P_RGATE] & ~s_reg.fault;

  always_comb begin
    s_next            = s_reg;
    s_next.ack        = wb_cyc_i && wb_stb_i && !s_reg.ack;
    s_next.clr_pulse  = 1'b0;
    s_next.lock_start = 1'b0;
    s_next.dat        = 32'h00000000;
    // Register writes land on the edge at which the master sees the acknowledge.
    if (s_reg.ack && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == `DDSC_ADR_CTRL) begin
        s_next.byte_en   = wb_dat_i[`DDSC_CTRL_BYTE_EN];
        s_next.clr_pulse = wb_dat_i[`DDSC_CTRL_CLR];
      end
    end
    // Unmapped addresses still answer, with zero data and no effect.
    if (s_next.ack && !wb_we_i) begin
      if (wb_adr_i == `DDSC_ADR_CTRL) begin
        s_next.dat[`DDSC_CTRL_BYTE_EN] = s_reg.byte_en;
      end else if (wb_adr_i == `DDSC_ADR_STATUS) begin
        s_next.dat[`DDSC_ST_FAULT]     = s_reg.fault;
        s_next.dat[`DDSC_ST_LOCKED]    = (s_reg.rd == ddsc_pkg::DDSC_RD_LOCK);
        s_next.dat[`DDSC_ST_SELECTED]  = s_reg.selected;
        s_next.dat[`DDSC_ST_CAPACITY]  = s_reg.capacity;
        s_next.dat[`DDSC_ST_READ_GATE] = pin_q[P_RGATE];
        s_next.dat[`DDSC_ST_RUNNING]   = run;
      end else if (wb_adr_i == `DDSC_ADR_BYTE_POS) begin
        s_next.dat[13:0] = byte_pos;
      end
    end
    // A new cause in the clearing cycle wins, so no fault is lost.
    if (clr_evt) begin
      s_next.fault = 1'b0;
    end
    if (wf_cond) begin
      s_next.fault = 1'b1;
    end
    s_next.wdrive = pin_q[P_WGATE] && !s_reg.fault && !wf_cond;
    // Read chain: acquire on zeros after the gate rises, then pass data.
    case (s_reg.rd)
      ddsc_pkg::DDSC_RD_IDLE: begin
        if (rg_ok) begin
          s_next.rd         = ddsc_pkg::DDSC_RD_ACQ;
          s_next.zero_cnt   = 7'h00;
          s_next.lock_start = 1'b1;
        end
      end
      ddsc_pkg::DDSC_RD_ACQ: begin
        if (!rg_ok) begin
          s_next.rd = ddsc_pkg::DDSC_RD_IDLE;
        end else if (pin_rise[P_RCLK]) begin
          if (pin_q[P_RRAW]) begin
            s_next.zero_cnt = 7'h00;
          end else if (s_reg.zero_cnt == 7'(LOCK_MAX - 1)) begin
            s_next.rd = ddsc_pkg::DDSC_RD_LOCK;
          end else begin
            s_next.zero_cnt = s_reg.zero_cnt + 7'h01;
          end
        end
      end
      ddsc_pkg::DDSC_RD_LOCK: begin
        if (!rg_ok) begin
          s_next.rd = ddsc_pkg::DDSC_RD_IDLE;
        end
      end
      default: begin
        s_next.rd = ddsc_pkg::DDSC_RD_IDLE;
      end
    endcase
    // A fresh cause reaches the latch one edge late, so it withholds data here too.
    if (s_reg.rd == ddsc_pkg::DDSC_RD_LOCK && rg_ok && !wf_cond) begin
      if (pin_rise[P_RCLK]) begin
        s_next.rd_data = pin_q[P_RRAW];
      end
    end else begin
      s_next.rd_data = 1'b0;
    end
    // Switching on one edge keeps the servo clock back well inside two periods.
    s_next.clk_out  = pin_q[P_RGATE] ? pin_q[P_RCLK] : pin_q[P_SERVO];
    s_next.selected = pin_q[P_SEL];
    s_next.capacity = pin_q[P_BASIC] & pin_q[P_OPT];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg         <= '0;
      s_reg.byte_en <= `DDSC_CTRL_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign wb_dat_o         = s_reg.dat;
  assign wb_ack_o         = s_reg.ack;
  // Only the command cable copies depend on selection.
  assign byte_clk_cmd_o   = bclk & s_reg.selected;
  assign byte_clk_data_o  = bclk;
  assign index_cmd_o      = index & s_reg.selected;
  assign index_data_o     = index;
  assign write_fault_o    = s_reg.fault;
  assign capacity_o       = s_reg.capacity;
  assign unit_selected_o  = s_reg.selected;
  assign servo_read_clk_o = s_reg.clk_out;
  assign read_data_o      = s_reg.rd_data;
  assign write_drive_en_o = s_reg.wdrive;
  assign lock_start_o     = s_reg.lock_start;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  fault_hold_a: assert property (
    (write_fault_o && !clr_evt) |=> write_fault_o)
    else $error("write fault dropped without a clear");
  fault_set_a: assert property (
    wf_cond |=> write_fault_o ##1 (write_fault_o || $past(clr_evt)))
    else $error("write fault not raised by its cause");
  fault_clear_a: assert property (
    (pin_rise[P_CLR] && !wf_cond) ##1 !wf_cond |-> ##[0:CLR_MAX] !write_fault_o)
    else $error("write fault not cleared in time");
  fault_block_a: assert property (
    write_fault_o |-> !write_drive_en_o && !read_data_o)
    else $error("disk access while write fault stands");
  byte_gate_a: assert property (
    byte_clk_cmd_o == (byte_clk_data_o && $past(pin_q[P_SEL])))
    else $error("command byte clock not gated by select");
  select_follow_a: assert property (
    $changed(pin_q[P_SEL]) |-> ##[1:SEL_MAX] unit_selected_o == pin_q[P_SEL])
    else $error("select acknowledge late");
  capacity_map_a: assert property (
    ##1 capacity_o == $past(pin_q[P_BASIC] && pin_q[P_OPT]))
    else $error("capacity output wrong");
  clock_mux_a: assert property (
    ##1 servo_read_clk_o == ($past(pin_q[P_RGATE]) ? $past(pin_q[P_RCLK])
                                                   : $past(pin_q[P_SERVO])))
    else $error("wrong clock on shared pair");
  read_zero_a: assert property (
    (s_reg.rd != ddsc_pkg::DDSC_RD_LOCK) |=> !read_data_o)
    else $error("read data before phase lock");
  lock_bound_a: assert property (
    (s_reg.rd == ddsc_pkg::DDSC_RD_ACQ) |-> s_reg.zero_cnt < 7'(LOCK_MAX))
    else $error("lock count beyond limit");
  lock_start_a: assert property (
    $rose(rg_ok) && s_reg.rd == ddsc_pkg::DDSC_RD_IDLE |=> lock_start_o)
    else $error("read gate rise did not start lock");
  wb_ack_a: assert property (
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not a single cycle");

  // Each of these ties an output or the read chain state to the levels and registers it must follow.
  index_gate_a: assert property (
    index_cmd_o == (index_data_o && $past(pin_q[P_SEL])))
    else $error("command index not gated by select");
  byte_stop_a: assert property (
    !run |=> !byte_clk_data_o && !index_data_o)
    else $error("byte timing while halted");
  write_drive_a: assert property (
    (pin_q[P_WGATE] && !write_fault_o && !wf_cond) |=> write_drive_en_o)
    else $error("write drive withheld without fault");
  fault_reg_clr_a: assert property (
    (s_reg.clr_pulse && !wf_cond) |=> !write_fault_o)
    else $error("register fault clear ignored");
  capacity_low_a: assert property (
    !pin_q[P_OPT] |=> !capacity_o)
    else $error("capacity high without optional media");
  servo_back_a: assert property (
    !pin_q[P_RGATE] |=> servo_read_clk_o == $past(pin_q[P_SERVO]))
    else $error("servo clock not back on the pair");
  read_pass_a: assert property (
    (s_reg.rd == ddsc_pkg::DDSC_RD_LOCK && rg_ok && !wf_cond && pin_rise[P_RCLK])
    |=> read_data_o == $past(pin_q[P_RRAW]))
    else $error("read data not passed after lock");
  read_idle_a: assert property (
    !rg_ok |=> s_reg.rd == ddsc_pkg::DDSC_RD_IDLE && !read_data_o)
    else $error("read chain active without read gate");
  lock_restart_a: assert property (
    (s_reg.rd == ddsc_pkg::DDSC_RD_ACQ && rg_ok && pin_rise[P_RCLK] && pin_q[P_RRAW])
    |=> s_reg.zero_cnt == 7'h00)
    else $error("zero count not restarted by a one");
  lock_reach_a: assert property (
    (s_reg.rd == ddsc_pkg::DDSC_RD_ACQ && rg_ok && pin_rise[P_RCLK] && !pin_q[P_RRAW] &&
     s_reg.zero_cnt == 7'(LOCK_MAX - 1)) |=> s_reg.rd == ddsc_pkg::DDSC_RD_LOCK)
    else $error("lock not declared after full preamble");
  lock_pulse_a: assert property (
    lock_start_o |-> s_reg.rd == ddsc_pkg::DDSC_RD_ACQ)
    else $error("lock start outside acquire");
  bus_idle_a: assert property (
    !wb_ack_o |-> wb_dat_o == 32'h00000000)
    else $error("read data outside answer cycle");
  select_low_a: assert property (
    !pin_q[P_SEL] |=> !unit_selected_o)
    else $error("select acknowledge without select");
endmodule : ddsc_status_clk

// File: tb/ddsc_ctrl_model.sv
// Controller side model: select, gating and fault clear lines, byte pulse counter.
`timescale 1ns/10ps
module ddsc_ctrl_model (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Timing from the drive's data cable.
  input  wire logic        byte_clk_i,
  input  wire logic        index_i,
  // Controller lines.
  output logic             select_o,
  output logic             read_gate_o,
  output logic             write_gate_o,
  output logic             fault_clear_o,
  output logic [1:0]       head_sel_o,
  // Byte pulses seen since the last track start marker.
  output logic [15:0]      byte_cnt_o
);
  logic byte_q;
  // Reserved interface lines are left unwired, so the drive sees logic 0.

  initial begin
    select_o      = 1'h0;
    read_gate_o   = 1'h0;
    write_gate_o  = 1'h0;
    fault_clear_o = 1'h0;
    head_sel_o    = 2'h0;
    byte_cnt_o    = 16'h0;
  end

  // The drive gives no sector signal, so sector position is this count alone.
  always @(posedge clk_i) begin
    byte_q <= byte_clk_i;
    if (rst_i || index_i) begin
      byte_cnt_o <= 16'h0;
    end else if (byte_clk_i && !byte_q) begin
      byte_cnt_o <= byte_cnt_o + 16'h1;
    end
  end

  task automatic lines(input logic sel, input logic rg, input logic wg, input logic [1:0] hd);
    @(posedge clk_i);
    select_o     <= sel;
    read_gate_o  <= rg;
    write_gate_o <= wg;
    head_sel_o   <= hd;
  endtask : lines

  // Held a little over one microsecond so a slow edge still meets the minimum.
  task automatic pulse_clear();
    @(posedge clk_i);
    fault_clear_o <= 1'h1;
    repeat (44) @(posedge clk_i);
    fault_clear_o <= 1'h0;
  endtask : pulse_clear
endmodule : ddsc_ctrl_model

// File: tb/ddsc_status_clk_bench.sv
// Self-checking bench for the drive status and clock output block.
`timescale 1ns/10ps
`include "ddsc_consts.svh"
module ddsc_status_clk_bench;
  logic        clk_i = 1'h0;
  logic        rst_i = 1'h1;
  logic        wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, wb_ack_o;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, exp_d;
  logic        servo_clk_i = 1'h0, read_clk_i = 1'h0, read_raw_i = 1'h0;
  logic        at_speed_i = 1'h0, in_zone_i = 1'h0, drive_ready_i = 1'h0;
  logic        basic_media_i = 1'h0, optional_media_i = 1'h0, multi_head_i = 1'h0;
  logic        write_current_i = 1'h0, write_data_act_i = 1'h0;
  logic        select_i, read_gate_i, write_gate_i, fault_clear_i;
  logic [1:0]  head_sel_i;
  logic        byte_clk_cmd_o, byte_clk_data_o, index_cmd_o, index_data_o, write_fault_o;
  logic        capacity_o, unit_selected_o, servo_read_clk_o, read_data_o;
  logic        write_drive_en_o, lock_start_o;
  logic [15:0] byte_cnt;
  logic [31:0] exp_q[$];
  int          fails = 0, n_checks = 0, seed = 70123;
  int          servo_n = 0, cmd_n = 0, ls_n = 0, src_n = 0;

  always #12.5 clk_i = ~clk_i;
  initial begin
    #7;
    forever #100 servo_clk_i = ~servo_clk_i;
  end
  initial begin
    #31;
    forever #75 read_clk_i = ~read_clk_i;
  end

  ddsc_status_clk dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .servo_clk_i(servo_clk_i),
    .read_clk_i(read_clk_i), .read_raw_i(read_raw_i), .at_speed_i(at_speed_i),
    .in_zone_i(in_zone_i), .drive_ready_i(drive_ready_i), .basic_media_i(basic_media_i),
    .optional_media_i(optional_media_i), .select_i(select_i), .read_gate_i(read_gate_i),
    .write_gate_i(write_gate_i), .head_sel_i(head_sel_i), .fault_clear_i(fault_clear_i),
    .write_current_i(write_current_i), .write_data_act_i(write_data_act_i),
    .multi_head_i(multi_head_i), .byte_clk_cmd_o(byte_clk_cmd_o),
    .byte_clk_data_o(byte_clk_data_o), .index_cmd_o(index_cmd_o),
    .index_data_o(index_data_o), .write_fault_o(write_fault_o), .capacity_o(capacity_o),
    .unit_selected_o(unit_selected_o), .servo_read_clk_o(servo_read_clk_o),
    .read_data_o(read_data_o), .write_drive_en_o(write_drive_en_o),
    .lock_start_o(lock_start_o));

  ddsc_ctrl_model ctrl_u (.clk_i(clk_i), .rst_i(rst_i), .byte_clk_i(byte_clk_data_o),
    .index_i(index_data_o), .select_o(select_i), .read_gate_o(read_gate_i),
    .write_gate_o(write_gate_i), .fault_clear_o(fault_clear_i), .head_sel_o(head_sel_i),
    .byte_cnt_o(byte_cnt));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic results();
    if (fails == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results

  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask : wt

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    @(posedge clk_i);
    while (wb_ack_o !== 1'h1) @(posedge clk_i);
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'h0, a, 32'h0);
  endtask : rd

  task automatic frozen();
    logic [15:0] b;
    wt(8);
    b = byte_cnt;
    wt(640);
    chk("halted byte clock", {16'h0, b}, {16'h0, byte_cnt});
  endtask : frozen

  // Rising edges on the shared clock pair over ten microseconds, counted with slack of one.
  task automatic rate(input int lo, input int hi);
    int s;
    s = src_n;
    wt(400);
    chk("clock pair rate", 32'h1, {31'h0, (src_n - s) >= lo && (src_n - s) <= hi});
  endtask : rate

  task automatic clr_chk(input logic e);
    fork
      ctrl_u.pulse_clear();
      begin
        wt(21);
        chk("fault after clear", {31'h0, e}, {31'h0, write_fault_o});
      end
    join
  endtask : clr_chk

  always @(posedge servo_clk_i) servo_n++;
  always @(posedge byte_clk_cmd_o) cmd_n++;
  always @(posedge servo_read_clk_o) src_n++;
  always @(posedge clk_i) begin
    if (lock_start_o === 1'h1) ls_n++;
    if (wb_ack_o === 1'h1 && wb_we_i === 1'h0) begin
      exp_d = (exp_q.size() != 0) ? exp_q.pop_front() : 32'hx;
      chk("read data", exp_d, wb_dat_o);
    end
  end

  initial begin
    repeat (90000) @(posedge clk_i);
    fails++;
    results();
  end

  initial begin : main
    int s0, d, c0;
    logic [15:0] b0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    rd(`DDSC_ADR_CTRL, 32'h1);
    wb(1'h1, 8'h40, $random(seed));
    rd(8'h40, 32'h0);
    basic_media_i <= 1'h1;
    at_speed_i    <= 1'h1;
    in_zone_i     <= 1'h1;
    drive_ready_i <= 1'h1;
    wt(8);
    chk("capacity basic", 32'h0, {31'h0, capacity_o});
    optional_media_i <= 1'h1;
    wt(8);
    chk("capacity both", 32'h1, {31'h0, capacity_o});
    ctrl_u.lines(1'h1, 1'h0, 1'h0, 2'h0);
    wt(40);
    chk("unit selected", 32'h1, {31'h0, unit_selected_o});
    rd(`DDSC_ADR_STATUS, 32'h2c);
    s0 = servo_n;
    b0 = byte_cnt;
    c0 = cmd_n;
    wt(3200);
    d = int'(byte_cnt - b0) - (servo_n - s0) / 8;
    chk("bytes per servo", 32'h1, {31'h0, d >= -1 && d <= 1});
    chk("command copy runs", 32'h1, {31'h0, cmd_n > c0});
    chk("no index mid track", 32'h0, {30'h0, index_data_o, index_cmd_o});
    ctrl_u.lines(1'h0, 1'h0, 1'h0, 2'h0);
    wt(40);
    chk("unit deselected", 32'h0, {31'h0, unit_selected_o});
    s0 = cmd_n;
    b0 = byte_cnt;
    wt(640);
    chk("command copy gated", s0, cmd_n);
    chk("data copy runs", 32'h1, {31'h0, byte_cnt != b0});
    at_speed_i <= 1'h0;
    frozen();
    at_speed_i <= 1'h1;
    wb(1'h1, `DDSC_ADR_CTRL, 32'h0);
    frozen();
    wb(1'h1, `DDSC_ADR_CTRL, 32'h1);
    ctrl_u.lines(1'h1, 1'h0, 1'h0, 2'h0);
    write_current_i <= 1'h1;
    wt(10);
    chk("stray current fault", 32'h1, {31'h0, write_fault_o});
    clr_chk(1'h1);
    write_current_i <= 1'h0;
    clr_chk(1'h0);
    write_current_i <= 1'h1;
    wt(10);
    write_current_i <= 1'h0;
    wt(8);
    chk("fault before reg clear", 32'h1, {31'h0, write_fault_o});
    wb(1'h1, `DDSC_ADR_CTRL, 32'h3);
    wt(2);
    chk("register clear", 32'h0, {31'h0, write_fault_o});
    rd(`DDSC_ADR_CTRL, 32'h1);
    // Gate and current change in one step, else a stray current fault would land first.
    ctrl_u.lines(1'h1, 1'h0, 1'h1, 2'h0);
    write_current_i  <= 1'h1;
    write_data_act_i <= 1'h1;
    wt(10);
    chk("clean write drive", 32'h1, {31'h0, write_drive_en_o});
    for (int k = 0; k < 6; k++) begin
      case (k)
        0: write_current_i <= 1'h0;
        1: write_data_act_i <= 1'h0;
        2: drive_ready_i <= 1'h0;
        3: multi_head_i <= 1'h1;
        4: ctrl_u.lines(1'h1, 1'h0, 1'h1, 2'h3);
        default: ctrl_u.lines(1'h1, 1'h1, 1'h1, 2'h0);
      endcase
      wt(10);
      chk("write cause fault", 32'h1, {31'h0, write_fault_o});
      chk("write blocked", 32'h0, {31'h0, write_drive_en_o});
      write_current_i  <= 1'h1;
      write_data_act_i <= 1'h1;
      drive_ready_i    <= 1'h1;
      multi_head_i     <= 1'h0;
      ctrl_u.lines(1'h1, 1'h0, 1'h1, 2'h0);
      wt(8);
      clr_chk(1'h0);
    end
    ctrl_u.lines(1'h1, 1'h0, 1'h0, 2'h0);
    write_current_i <= 1'h0;
    wt(8);
    s0 = ls_n;
    ctrl_u.lines(1'h1, 1'h1, 1'h0, 2'h0);
    wt(8);
    chk("lock start pulse", s0 + 1, ls_n);
    wt(232);
    chk("data held low", 32'h0, {31'h0, read_data_o});
    rd(`DDSC_ADR_STATUS, 32'h3c);
    wt(360);
    rd(`DDSC_ADR_STATUS, 32'h3e);
    rate(65, 68);
    d = 0;
    for (int k = 0; k < 200; k++) begin
      @(posedge clk_i);
      read_raw_i <= $random(seed);
      if (read_data_o === 1'h1) d++;
    end
    chk("read data passes", 32'h1, {31'h0, d > 0});
    read_raw_i <= 1'h0;
    ctrl_u.lines(1'h1, 1'h0, 1'h0, 2'h0);
    wt(16);
    chk("data idle low", 32'h0, {31'h0, read_data_o});
    rate(49, 51);
    results();
  end
endmodule : ddsc_status_clk_bench
